//--- bench/pvt_link_checker.sv
// Timing checks on the link wires between the two ends
`timescale 1ns/100ps
`include "pvt_consts.svh"
module pvt_link_checker
    import pvt_pkg::*;
(
    input wire logic         sys_clk_in,
    input wire logic         nrst_in,
    input wire logic         link_clk,
    input wire pvt_lane_type link_data_lane_0,
    input wire pvt_lane_type link_data_lane_2,
    input wire pvt_lane_type link_data_lane_3,
    input wire logic         colour_depth_select
);
    // ====
    // Link period counters
    logic        clk_d_reg;
    logic        de_d_reg;
    logic [10:0] act_reg;
    logic [15:0] per_reg;
    wire         de    = link_data_lane_2[`PVT_L2_DE];
    wire         lrise = link_clk && !clk_d_reg;
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) clk_d_reg <= 1'b1;
        else clk_d_reg <= link_clk;
    end
    // Period count spans blank lines, so only whole multiples are checked
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            de_d_reg <= 1'b0;
            act_reg  <= 11'h000;
            per_reg  <= 16'h0000;
        end else if (lrise) begin
            de_d_reg <= de;
            act_reg  <= de ? act_reg + 11'h001 : 11'h000;
            if (de && !de_d_reg) per_reg <= 16'h0001;
            else if (per_reg != 16'h0000) per_reg <= per_reg + 16'h0001;
        end
    end
    // ====
    // Assertions
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence high_run; link_clk[*4] ##1 !link_clk; endsequence
    sequence low_run; !link_clk[*3] ##1 link_clk; endsequence
    clk_high_a: assert property ($rose(link_clk) |-> high_run)
        else $error("link clock high time wrong");
    clk_low_a: assert property ($fell(link_clk) |-> low_run)
        else $error("link clock low time wrong");
    lane_hold_a: assert property (!$fell(link_clk) |->
        $stable(link_data_lane_0) && $stable(link_data_lane_2)) else $error("lane changed off falling edge");
    lane3_idle_a: assert property (colour_depth_select && $stable(colour_depth_select) |->
        link_data_lane_3 == '0) else $error("lane 3 busy in 6-bit mode");
    sync_blank_a: assert property (link_data_lane_2[`PVT_L2_HS] || link_data_lane_2[`PVT_L2_VS] |-> !de)
        else $error("sync inside active data");
    active_count_a: assert property (lrise && !de && de_d_reg |-> act_reg == `PVT_H_ACTIVE)
        else $error("active pixel count wrong");
    line_total_a: assert property (lrise && de && !de_d_reg && per_reg != 0 |->
        per_reg % `PVT_H_TOTAL == 0) else $error("line period wrong");
    reset_idle_a: assert property ($rose(nrst_in) |-> link_clk && link_data_lane_0 == '0)
        else $error("link not idle in reset");
endmodule

//--- bench/tb_panel_video_timing_and_control.sv
// Self-checking bench: host end drives the panel end over the link
`timescale 1ns/100ps
module tb_panel_video_timing_and_control
    import pvt_pkg::*;
;
    logic        sys_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        pix_valid_in = 1'b0;
    pvt_rgb_type pix_data_in = '0;
    logic        video_enable_in = 1'b0;
    logic        mode = 1'b0;
    logic        feed = 1'b0;
    logic [16:0] lfsr = 17'h1026D;
    logic        pix_ready_out, underrun_out, pixel_valid_out, line_error_out;
    pvt_rgb_type pixel_rgb_out;
    logic        video_running_out, line_sync_out, frame_sync_out, six_bit_mode_out, scan_reverse_out;
    logic        backlight_on_out, dim_pulse_out, frame_error_out;
    logic [9:0]  pixel_x_out, pixel_y_out;
    logic [9:0]  px = 10'h000;
    logic [9:0]  py = 10'h000;
    pvt_rgb_type exp_q[$];
    int          fails = 0;
    int          n_checks = 0;
    int          n_push = 0;
    pvt_link_if link ();
    pvt_host #(.DIM_PERIOD_CYCLES(100)) pvt_host_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .pix_valid_in(pix_valid_in), .pix_data_in(pix_data_in), .pix_ready_out(pix_ready_out),
        .video_enable_in(video_enable_in), .six_bit_mode_in(mode), .scan_reverse_in(mode),
        .backlight_request_in(feed), .dim_duty_in(8'h40), .video_running_out(video_running_out),
        .underrun_out(underrun_out), .link(link));
    pvt_panel pvt_panel_i (.nrst_in(nrst_in), .link(link), .pixel_rgb_out(pixel_rgb_out),
        .pixel_valid_out(pixel_valid_out), .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
        .pixel_x_out(pixel_x_out), .pixel_y_out(pixel_y_out), .six_bit_mode_out(six_bit_mode_out),
        .scan_reverse_out(scan_reverse_out), .backlight_on_out(backlight_on_out), .dim_pulse_out(dim_pulse_out),
        .line_error_out(line_error_out), .frame_error_out(frame_error_out));
    pvt_link_checker pvt_link_checker_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .link_clk(link.link_clk), .link_data_lane_0(link.link_data_lane_0),
        .link_data_lane_2(link.link_data_lane_2), .link_data_lane_3(link.link_data_lane_3),
        .colour_depth_select(link.colour_depth_select));
    // ====
    // Helpers
    always #10 sys_clk_in = ~sys_clk_in;
    function automatic logic [16:0] lfsr_step(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Producer notes every accepted pixel; data held until taken
    always @(posedge sys_clk_in) begin
        if (pix_valid_in && pix_ready_out) begin
            exp_q.push_back(pix_data_in);
            n_push++;
        end
        if (!pix_valid_in || pix_ready_out) begin
            lfsr = lfsr_step(lfsr);
            #1;
            pix_valid_in = feed;
            pix_data_in = {lfsr, lfsr[6:0]};
        end
    end
    // Low two bits of each colour are lost in 6-bit mode
    // Sampled on the falling link edge, well away from the edge that launches them
    always @(negedge link.link_clk) begin
        if (pixel_valid_out === 1'b1) begin
            check(pixel_rgb_out, exp_q.size() ? exp_q.pop_front() & (mode ? 24'hFCFCFC : 24'hFFFFFF) : '0);
            check({line_sync_out, frame_sync_out, pixel_y_out, pixel_x_out},
                  mode ? {2'h0, 10'h2FF - py, 10'h3FF - px} : {2'h0, py, px});
            if (px == 10'h3FF) py++;
            px++;
        end
    end
    // ====
    // Tests
    initial begin
        #2000000;
        fails++;
        tally_and_finish;
    end
    initial begin
        for (int m = 0; m < 2; m++) begin
            nrst_in = 1'b0;
            mode = m[0];
            repeat (10) @(posedge sys_clk_in);
            exp_q.delete();
            n_push = 0;
            px = 10'h000;
            py = 10'h000;
            #1;
            nrst_in = 1'b1;
            check(pix_ready_out, 1'b1);
            feed = 1'b1;
            repeat (40) @(posedge sys_clk_in);
            #1;
            check(24'(n_push), 24'h000010);
            check(pix_ready_out, 1'b0);
            video_enable_in = 1'b1;
            repeat (3 * 1344 * 7) @(posedge sys_clk_in);
            #1;
            check(link.colour_depth_select, m[0]);
            check(link.scan_reverse_select, m[0]);
            check(line_error_out, 1'b0);
            check(underrun_out, 1'b0);
            check(link.backlight_converter_enable, 1'b0);
            check(six_bit_mode_out, m[0]);
            check(scan_reverse_out, m[0]);
            check({video_running_out, frame_error_out}, 2'h2);
            check({backlight_on_out, dim_pulse_out}, 2'h0);
            feed = 1'b0;
            video_enable_in = 1'b0;
            $display("Test mode %0d done", m);
        end
        tally_and_finish;
    end
endmodule

//--- hw/pvt_consts.svh
// Timing, geometry and lane layout constants for the panel video link
`ifndef PVT_CONSTS_SVH
`define PVT_CONSTS_SVH

// ==========================================================================
// System clock
`define PVT_SYS_CLK_PERIOD_NS 20

// ==========================================================================
// Link clock divider: 4 of 7 system cycles high, 3 low
`define PVT_LINK_DIV         3'h7
`define PVT_LINK_HIGH_CYCLES 3'h4
`define PVT_LINK_LAST_HIGH   3'h3
`define PVT_LANE_BITS        7

// ==========================================================================
// Line timing in pixel clocks
`define PVT_H_ACTIVE      11'h400
`define PVT_H_TOTAL       11'h540
`define PVT_H_TOTAL_MIN   11'h45A
`define PVT_H_TOTAL_MAX   11'h578
`define PVT_H_SYNC_START  11'h418
`define PVT_H_SYNC_END    11'h4A0

// ==========================================================================
// Frame timing in lines
`define PVT_V_ACTIVE      10'h300
`define PVT_V_TOTAL       10'h326
`define PVT_V_TOTAL_MIN   10'h30A
`define PVT_V_TOTAL_MAX   10'h34D
`define PVT_V_SYNC_START  10'h303
`define PVT_V_SYNC_END    10'h309

// ==========================================================================
// Pixel clock limits in MHz
`define PVT_PCLK_MIN_MHZ  52
`define PVT_PCLK_TYP_MHZ  65
`define PVT_PCLK_MAX_MHZ  71

// ==========================================================================
// Dimming pulse: 10 kHz, duty floor above one tenth
`define PVT_DIM_PERIOD_NS   100000
`define PVT_DIM_MIN_DIV     10

// ==========================================================================
// Lane 2 control bit positions
`define PVT_L2_HS  4
`define PVT_L2_VS  5
`define PVT_L2_DE  6

`endif

//--- hw/pvt_host.sv
// Video source end: pixel FIFO, timing generator, link serializer, backlight control
`timescale 1ns/100ps
`include "pvt_consts.svh"

// ==========================================================================
// Pixel FIFO
module pvt_fifo
    import pvt_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_in,
    input  wire logic             nrst_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             ready_reg;
    logic             push;
    logic             pop;

    assign push          = in_valid_in && ready_reg;
    assign pop           = out_ready_in && (count_reg != '0);
    assign in_ready_out  = ready_reg;
    assign out_valid_out = (count_reg != '0);
    assign out_data_out  = mem_reg[rd_ptr_reg];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg  <= '0;
            ready_reg  <= 1'b1;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            count_reg <= count_next;
            ready_reg <= (count_next != (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end
endmodule

// ==========================================================================
// Host end
module pvt_host
    import pvt_pkg::*;
#(
    parameter int DIM_PERIOD_CYCLES = `PVT_DIM_PERIOD_NS / `PVT_SYS_CLK_PERIOD_NS
) (
    input  wire logic     sys_clk_in,
    input  wire logic     nrst_in,
    input  wire logic     pix_valid_in,
    input  wire pvt_rgb_type pix_data_in,
    output logic          pix_ready_out,
    input  wire logic     video_enable_in,
    input  wire logic     six_bit_mode_in,
    input  wire logic     scan_reverse_in,
    input  wire logic     backlight_request_in,
    input  wire logic [7:0] dim_duty_in,
    output logic          video_running_out,
    output logic          underrun_out,
    pvt_link_if.host      link
);
    // ======================================================================
    // Declarations
    logic [2:0]       div_cnt_reg;
    logic             link_clk_reg;
    logic             pix_tick;
    logic             run_reg;
    logic [10:0]      h_cnt_reg;
    logic [9:0]       v_cnt_reg;
    logic             frame_end;
    logic             active;
    logic             fifo_valid;
    pvt_rgb_type      fifo_data;
    logic             fifo_pop;
    pvt_rgb_type      pix;
    logic             six_mode_reg;
    logic             reverse_reg;
    pvt_lane_type     lane_reg [4];
    pvt_bl_state_type bl_state_reg;
    logic             bl_en_reg;
    logic [31:0]      dim_cnt_reg;
    logic [31:0]      dim_high;
    logic [31:0]      dim_scaled;
    logic             dim_reg;
    logic             underrun_reg;

    // ======================================================================
    // Pixel FIFO; ready back-pressures the pixel source
    pvt_fifo #(
        .WIDTH (24),
        .DEPTH (16)
    ) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .nrst_in       (nrst_in),
        .in_valid_in   (pix_valid_in),
        .in_data_in    (pix_data_in),
        .in_ready_out  (pix_ready_out),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (fifo_pop)
    );

    // ======================================================================
    // Link clock divider
    // Lanes change as the clock falls so the panel samples mid-period
    // Rate tracks the system clock: 50 MHz gives 7.14 MHz, under the panel's range
    assign pix_tick = (div_cnt_reg == `PVT_LINK_LAST_HIGH);

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt_reg  <= 3'h0;
            link_clk_reg <= 1'b1;
        end else begin
            if (div_cnt_reg == `PVT_LINK_DIV - 3'h1) begin
                div_cnt_reg  <= 3'h0;
                link_clk_reg <= 1'b1;
            end else begin
                div_cnt_reg  <= div_cnt_reg + 3'h1;
                link_clk_reg <= (div_cnt_reg + 3'h1 < `PVT_LINK_HIGH_CYCLES);
            end
        end
    end

    // ======================================================================
    // Line and frame counters
    assign frame_end = (h_cnt_reg == `PVT_H_TOTAL - 11'h1) && (v_cnt_reg == `PVT_V_TOTAL - 10'h1);
    assign active    = run_reg && (h_cnt_reg < `PVT_H_ACTIVE) && (v_cnt_reg < `PVT_V_ACTIVE);
    assign fifo_pop  = pix_tick && active && fifo_valid;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_reg <= 1'b0;
        end else if (pix_tick && (frame_end || !run_reg)) begin
            // Start and stop only on frame boundaries
            run_reg <= video_enable_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            h_cnt_reg <= 11'h0;
            v_cnt_reg <= 10'h0;
        end else if (pix_tick) begin
            if (!run_reg || h_cnt_reg == `PVT_H_TOTAL - 11'h1) begin
                h_cnt_reg <= 11'h0;
            end else begin
                h_cnt_reg <= h_cnt_reg + 11'h1;
            end
            if (!run_reg || frame_end) begin
                v_cnt_reg <= 10'h0;
            end else if (h_cnt_reg == `PVT_H_TOTAL - 11'h1) begin
                v_cnt_reg <= v_cnt_reg + 10'h1;
            end
        end
    end

    // ======================================================================
    // Straps, latched at frame start so a frame never mixes depths
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            six_mode_reg <= 1'b0;
            reverse_reg  <= 1'b0;
        end else if (pix_tick && (frame_end || !run_reg)) begin
            six_mode_reg <= six_bit_mode_in;
            reverse_reg  <= scan_reverse_in;
        end
    end

    // ======================================================================
    // Lane packing: upper six colour bits on lanes 0-2, low bits on lane 3
    // Underrun sends black rather than stalling the fixed line timing
    assign pix = fifo_pop ? fifo_data : 24'h000000;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lane_reg[0] <= 7'h00;
            lane_reg[1] <= 7'h00;
            lane_reg[2] <= 7'h00;
            lane_reg[3] <= 7'h00;
        end else if (pix_tick) begin
            lane_reg[0] <= {pix[10], pix[23:18]};
            lane_reg[1] <= {pix[3:2], pix[15:11]};
            lane_reg[2] <= {active,
                            run_reg && v_cnt_reg >= `PVT_V_SYNC_START && v_cnt_reg < `PVT_V_SYNC_END,
                            run_reg && h_cnt_reg >= `PVT_H_SYNC_START && h_cnt_reg < `PVT_H_SYNC_END,
                            pix[7:4]};
            lane_reg[3] <= six_mode_reg ? 7'h00 : {1'b0, pix[1:0], pix[9:8], pix[17:16]};
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            underrun_reg <= 1'b0;
        end else if (!run_reg) begin
            underrun_reg <= 1'b0;
        end else if (pix_tick && active && !fifo_valid) begin
            underrun_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Backlight: enable at the first frame end after a request while video runs
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bl_state_reg <= PVT_BL_OFF;
            bl_en_reg    <= 1'b0;
        end else begin
            unique case (bl_state_reg)
                PVT_BL_OFF: begin
                    if (backlight_request_in && run_reg) begin
                        bl_state_reg <= PVT_BL_WAIT;
                    end
                end
                PVT_BL_WAIT: begin
                    if (!backlight_request_in || !run_reg) begin
                        bl_state_reg <= PVT_BL_OFF;
                    end else if (pix_tick && frame_end) begin
                        bl_state_reg <= PVT_BL_ON;
                        bl_en_reg    <= 1'b1;
                    end
                end
                PVT_BL_ON: begin
                    if (!backlight_request_in || !run_reg) begin
                        bl_state_reg <= PVT_BL_OFF;
                        bl_en_reg    <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // Dimming pulse with a duty floor just above one tenth
    assign dim_scaled = (DIM_PERIOD_CYCLES * 32'(dim_duty_in)) >> 8;
    assign dim_high   = (dim_scaled > DIM_PERIOD_CYCLES / `PVT_DIM_MIN_DIV) ? dim_scaled
                        : 32'(DIM_PERIOD_CYCLES / `PVT_DIM_MIN_DIV + 1);

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dim_cnt_reg <= 32'h00000000;
            dim_reg     <= 1'b0;
        end else begin
            if (dim_cnt_reg == 32'(DIM_PERIOD_CYCLES - 1)) begin
                dim_cnt_reg <= 32'h00000000;
            end else begin
                dim_cnt_reg <= dim_cnt_reg + 32'h00000001;
            end
            dim_reg <= (dim_cnt_reg < dim_high);
        end
    end

    // ======================================================================
    // Outputs, all from flops
    assign link.link_clk                   = link_clk_reg;
    assign link.link_data_lane_0           = lane_reg[0];
    assign link.link_data_lane_1           = lane_reg[1];
    assign link.link_data_lane_2           = lane_reg[2];
    assign link.link_data_lane_3           = lane_reg[3];
    assign link.colour_depth_select        = six_mode_reg;
    assign link.scan_reverse_select        = reverse_reg;
    assign link.backlight_converter_enable = bl_en_reg;
    assign link.backlight_dim_pulse        = dim_reg;
    assign video_running_out               = run_reg;
    assign underrun_out                    = underrun_reg;
endmodule

//--- hw/pvt_link_if.sv
// Link between the video source and the panel: four lanes, clock, straps
`timescale 1ns/100ps
interface pvt_link_if;
    import pvt_pkg::*;

    logic         link_clk;
    pvt_lane_type link_data_lane_0;
    pvt_lane_type link_data_lane_1;
    pvt_lane_type link_data_lane_2;
    pvt_lane_type link_data_lane_3;
    logic         colour_depth_select;
    logic         scan_reverse_select;
    logic         backlight_converter_enable;
    logic         backlight_dim_pulse;

    modport host (
        output link_clk,
        output link_data_lane_0,
        output link_data_lane_1,
        output link_data_lane_2,
        output link_data_lane_3,
        output colour_depth_select,
        output scan_reverse_select,
        output backlight_converter_enable,
        output backlight_dim_pulse
    );

    modport panel (
        input link_clk,
        input link_data_lane_0,
        input link_data_lane_1,
        input link_data_lane_2,
        input link_data_lane_3,
        input colour_depth_select,
        input scan_reverse_select,
        input backlight_converter_enable,
        input backlight_dim_pulse
    );
endinterface

//--- hw/pvt_panel.sv
// Panel end: lane capture, pixel decode, scan order and timing checks
`timescale 1ns/100ps
`include "pvt_consts.svh"

module pvt_panel
    import pvt_pkg::*;
(
    input  wire logic  nrst_in,
    pvt_link_if.panel  link,
    output pvt_rgb_type pixel_rgb_out,
    output logic       pixel_valid_out,
    output logic       line_sync_out,
    output logic       frame_sync_out,
    output logic [9:0] pixel_x_out,
    output logic [9:0] pixel_y_out,
    output logic       six_bit_mode_out,
    output logic       scan_reverse_out,
    output logic       backlight_on_out,
    output logic       dim_pulse_out,
    output logic       line_error_out,
    output logic       frame_error_out
);
    // ======================================================================
    // Declarations
    logic         rst_meta_reg;
    logic         rst_sync_reg;
    pvt_lane_type lane_meta_reg [4];
    pvt_lane_type lane_reg      [4];
    logic [3:0]   ctl_meta_reg;
    logic [3:0]   ctl_reg;
    pvt_lane_type lane_in       [4];
    logic [3:0]   ctl_in;
    logic         de;
    logic         vs;
    logic         de_d_reg;
    logic         vs_d_reg;
    logic         six_reg;
    logic         rev_reg;
    logic [10:0]  x_reg;
    logic [9:0]   y_reg;
    pvt_rgb_type  rgb_reg;
    logic         valid_reg;
    logic         hs_reg;
    logic         vs_reg;
    logic [9:0]   xo_reg;
    logic [9:0]   yo_reg;
    logic         line_err_reg;
    logic         frame_err_reg;
    logic         dim_on_reg;

    assign lane_in[0] = link.link_data_lane_0;
    assign lane_in[1] = link.link_data_lane_1;
    assign lane_in[2] = link.link_data_lane_2;
    assign lane_in[3] = link.link_data_lane_3;
    assign ctl_in     = {link.backlight_dim_pulse, link.backlight_converter_enable,
                         link.scan_reverse_select, link.colour_depth_select};

    // ======================================================================
    // Reset release synchronised to the link clock
    always_ff @(posedge link.link_clk or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ======================================================================
    // Two-stage capture of every incoming pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            always_ff @(posedge link.link_clk or negedge rst_sync_reg) begin
                if (!rst_sync_reg) begin
                    lane_meta_reg[gi] <= 7'h00;
                    lane_reg[gi]      <= 7'h00;
                    ctl_meta_reg[gi]  <= 1'b0;
                    ctl_reg[gi]       <= 1'b0;
                end else begin
                    lane_meta_reg[gi] <= lane_in[gi];
                    lane_reg[gi]      <= lane_meta_reg[gi];
                    ctl_meta_reg[gi]  <= ctl_in[gi];
                    ctl_reg[gi]       <= ctl_meta_reg[gi];
                end
            end
        end
    endgenerate

    assign de = lane_reg[2][`PVT_L2_DE];
    assign vs = lane_reg[2][`PVT_L2_VS];

    // ======================================================================
    // Straps follow the pins only in the blanking before line 0, where the host changes them
    always_ff @(posedge link.link_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            six_reg  <= 1'b0;
            rev_reg  <= 1'b0;
            de_d_reg <= 1'b0;
            vs_d_reg <= 1'b0;
            dim_on_reg <= 1'b0;
        end else begin
            de_d_reg <= de;
            vs_d_reg <= vs;
            dim_on_reg <= ctl_reg[3] && ctl_reg[2];
            if (!de && y_reg == 10'h0) begin
                six_reg <= ctl_reg[0];
                rev_reg <= ctl_reg[1];
            end
        end
    end

    // ======================================================================
    // Pixel decode; 6-bit mode ignores lane 3
    always_ff @(posedge link.link_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            rgb_reg   <= 24'h000000;
            valid_reg <= 1'b0;
            hs_reg    <= 1'b0;
            vs_reg    <= 1'b0;
        end else begin
            rgb_reg   <= {lane_reg[0][5:0], six_reg ? 2'h0 : lane_reg[3][1:0],
                          lane_reg[1][4:0], lane_reg[0][6], six_reg ? 2'h0 : lane_reg[3][3:2],
                          lane_reg[2][3:0], lane_reg[1][6:5], six_reg ? 2'h0 : lane_reg[3][5:4]};
            valid_reg <= de;
            hs_reg    <= lane_reg[2][`PVT_L2_HS];
            vs_reg    <= vs;
        end
    end

    // ======================================================================
    // Position counters and timing checks
    always_ff @(posedge link.link_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            x_reg         <= 11'h0;
            y_reg         <= 10'h0;
            xo_reg        <= 10'h0;
            yo_reg        <= 10'h0;
            line_err_reg  <= 1'b0;
            frame_err_reg <= 1'b0;
        end else begin
            if (de) begin
                x_reg  <= x_reg + 11'h1;
                xo_reg <= rev_reg ? 10'(`PVT_H_ACTIVE - 11'h1 - x_reg) : x_reg[9:0];
                yo_reg <= rev_reg ? (`PVT_V_ACTIVE - 10'h1 - y_reg) : y_reg;
            end else if (de_d_reg) begin
                x_reg        <= 11'h0;
                y_reg        <= y_reg + 10'h1;
                line_err_reg <= (x_reg != `PVT_H_ACTIVE);
            end
            if (vs && !vs_d_reg) begin
                y_reg         <= 10'h0;
                frame_err_reg <= (y_reg != `PVT_V_ACTIVE);
            end
        end
    end

    // ======================================================================
    // Outputs
    assign pixel_rgb_out    = rgb_reg;
    assign pixel_valid_out  = valid_reg;
    assign line_sync_out    = hs_reg;
    assign frame_sync_out   = vs_reg;
    assign pixel_x_out      = xo_reg;
    assign pixel_y_out      = yo_reg;
    assign six_bit_mode_out = six_reg;
    assign scan_reverse_out = rev_reg;
    assign backlight_on_out = ctl_reg[2];
    assign dim_pulse_out    = dim_on_reg;
    assign line_error_out   = line_err_reg;
    assign frame_error_out  = frame_err_reg;
endmodule

//--- hw/pvt_pkg.sv
// Types shared by both ends of the panel video link
package pvt_pkg;

    typedef logic [6:0]  pvt_lane_type;
    typedef logic [23:0] pvt_rgb_type;

    typedef enum logic [1:0] {
        PVT_BL_OFF,
        PVT_BL_WAIT,
        PVT_BL_ON
    } pvt_bl_state_type;

endpackage
